// File: src/uia_map.vh
// Constants for the universal input acquisition block: mode codes, ranges,
// defaults and timing counts. Definitions only.
`ifndef UIA_MAP_VH
`define UIA_MAP_VH

// Measurement type codes
`define UIA_MODE_OFF 3'h0
`define UIA_MODE_VOLT 3'h1
`define UIA_MODE_CURR 3'h2
`define UIA_MODE_RES 3'h3
`define UIA_MODE_DISC 3'h4
`define UIA_MODE_FREQ 3'h5
`define UIA_MODE_DUTY 3'h6
`define UIA_MODE_RST `UIA_MODE_VOLT

// Voltage range codes, full scale in the name
`define UIA_VR_10V 2'h0
`define UIA_VR_5V 2'h1
`define UIA_VR_2V5 2'h2
`define UIA_VR_1V 2'h3
`define UIA_VR_RST `UIA_VR_5V
// Current ranges
`define UIA_IR_0_20 1'b0
`define UIA_IR_4_20 1'b1
`define UIA_IR_RST `UIA_IR_0_20
// Frequency bands
`define UIA_FB_LOW 1'b0
`define UIA_FB_HIGH 1'b1
`define UIA_FB_RST `UIA_FB_LOW

// Analog noise filter: off, 50 Hz, 60 Hz, both
`define UIA_AF_OFF 2'h0
`define UIA_AF_50 2'h1
`define UIA_AF_60 2'h2
`define UIA_AF_BOTH 2'h3
`define UIA_AF_RST `UIA_AF_BOTH
`define UIA_AF_PTS_50 7'd18
`define UIA_AF_PTS_60 7'd15
`define UIA_AF_PTS_BOTH 7'd90

// Debounce filter settings and times in ns
`define UIA_DB_OFF 2'h0
`define UIA_DB_111N 2'h1
`define UIA_DB_1U78 2'h2
`define UIA_DB_14U22 2'h3
`define UIA_DB_RST `UIA_DB_1U78
`define UIA_DB_T1_NS 111
`define UIA_DB_T2_NS 1780
`define UIA_DB_T3_NS 14220
`define UIA_CLK_NS 100
// Least times round up, never below one cycle
`define UIA_DB_CYC(t) (((t) + `UIA_CLK_NS - 1) / `UIA_CLK_NS)

// Discrete debounce, 100 ms
`define UIA_DISC_DB_MS 100
`define UIA_DISC_DB_CYC (`UIA_DISC_DB_MS * 1000000 / `UIA_CLK_NS)

// Polarity
`define UIA_POL_HIGH 1'b0
`define UIA_POL_RST `UIA_POL_HIGH

// Software filter types and constant
`define UIA_SF_NONE 2'h0
`define UIA_SF_MOVE 2'h1
`define UIA_SF_REPEAT 2'h2
`define UIA_SF_RST `UIA_SF_NONE
`define UIA_SFK_MAX 16'd60000
`define UIA_SFK_RST 16'd10

// Normalization limits, fixed point with 3 decimals (mV, uA, ohm, mHz, 0.001 %)
`define UIA_VMAX_RST 32'd5000
`define UIA_VMIN_RST 32'd0
`define UIA_VLIM 32'd10000
`define UIA_IMAX_RST 32'd20000
`define UIA_IMIN_RST 32'd0
`define UIA_ILIM 32'd20000
`define UIA_RMAX_RST 32'd250000
`define UIA_RMIN_RST 32'd30
`define UIA_RLIM 32'd250000
`define UIA_FMAX_RST 32'd1000000
`define UIA_FMIN_RST 32'd40
`define UIA_FLIM 32'd10000000
`define UIA_DMAX_RST 32'd100000
`define UIA_DMIN_RST 32'd0
`define UIA_DLIM 32'd100000

// Frequency band error limits in mHz
`define UIA_FLO_MIN 32'd9155
`define UIA_FLO_MAX 32'd1200000
`define UIA_FHI_MIN 32'd91550
`define UIA_FHI_MAX 32'd12000000

// Output state codes
`define UIA_ST_VALID 2'h0
`define UIA_ST_ERROR 2'h1
`define UIA_ERR_LOW 32'h0
`define UIA_ERR_HIGH 32'h1
`define UIA_NORM_ONE 16'hffff

`endif

// File: src/uia_debounce.v
// Debounce filter: output follows the input only after it held steady
// for the selected count. Assumes the input is synchronous to sys_clk.
`timescale 1ns/1ns
module uia_debounce #(
   parameter CNT_W = 20
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Filter control
   input wire bypass,
   input wire [CNT_W-1:0] hold_cyc,
   // Data
   input wire din,
   output reg dout_q
);
   reg [CNT_W-1:0] cnt_q;

   // Restart count on any change; a zero count behaves as bypass
   always @(posedge sys_clk) begin
      if (reset) begin
         cnt_q <= {CNT_W{1'b0}};
         dout_q <= 1'b0;
      end else if (bypass || din == dout_q) begin
         cnt_q <= {CNT_W{1'b0}};
         if (bypass)
            dout_q <= din;
      end else if (cnt_q + 1'b1 >= hold_cyc) begin
         cnt_q <= {CNT_W{1'b0}};
         dout_q <= din;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule // uia_debounce

// File: src/uia_swfilter.v
// Software filter on a sample stream: none, moving or repeating average.
// Assumes one sample strobe per new measured value.
`timescale 1ns/1ns
`include "uia_map.vh"
module uia_swfilter (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Filter control
   input wire [1:0] ftype,
   input wire [15:0] fconst,
   // Sample stream
   input wire smp_stb,
   input wire [31:0] smp,
   output reg [31:0] val_q,
   output reg val_stb_q
);
   reg [47:0] acc_q;
   reg [15:0] n_q;
   wire [15:0] k = (fconst == 16'd0) ? 16'd1 : fconst;
   wire signed [33:0] diff = $signed({2'b00, smp}) - $signed({2'b00, val_q});
   wire signed [33:0] step = diff / $signed({18'd0, k});
   wire [47:0] acc_n = acc_q + {16'd0, smp};
   wire [47:0] avg_n = acc_n / {32'd0, k};

   // Moving average tracks a fraction of the error; repeating sums k samples
   always @(posedge sys_clk) begin
      if (reset) begin
         val_q <= 32'h0;
         val_stb_q <= 1'b0;
         acc_q <= 48'h0;
         n_q <= 16'h0;
      end else begin
         val_stb_q <= 1'b0;
         if (smp_stb) begin
            case (ftype)
               `UIA_SF_MOVE: begin
                  val_q <= val_q + step[31:0];
                  val_stb_q <= 1'b1;
               end
               `UIA_SF_REPEAT: begin
                  if (n_q + 1'b1 >= k) begin
                     val_q <= avg_n[31:0];
                     val_stb_q <= 1'b1;
                     acc_q <= 48'h0;
                     n_q <= 16'h0;
                  end else begin
                     acc_q <= acc_n;
                     n_q <= n_q + 1'b1;
                  end
               end
               default: begin
                  val_q <= smp;
                  val_stb_q <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule // uia_swfilter

// File: src/uia_acquire.v
// Universal input acquisition: mode select, analog averaging, debounce,
// frequency/duty measurement, software filter, normalization to [0;1].
// Assumes ADC samples arrive as fixed-point values with a strobe, and all
// inputs are synchronous to sys_clk.
`timescale 1ns/1ns
`include "uia_map.vh"
module uia_acquire #(
   parameter DISC_DB_CYC = `UIA_DISC_DB_CYC,
   parameter TICK_HZ = 10000000
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Configuration setpoints
   input wire [2:0] cfg_mode,
   input wire [1:0] cfg_vrange,
   input wire cfg_irange,
   input wire cfg_fband,
   input wire [1:0] cfg_afilt,
   input wire [1:0] cfg_dbfilt,
   input wire cfg_pol_low,
   input wire [1:0] cfg_sftype,
   input wire [15:0] cfg_sfconst,
   input wire cfg_wr,
   // Limit writes: select 0 volt, 1 current, 2 resistance, 3 frequency, 4 duty
   input wire lim_wr,
   input wire [2:0] lim_sel,
   input wire [31:0] lim_max,
   input wire [31:0] lim_min,
   output wire lim_rej,
   // Physical input
   input wire adc_stb,
   input wire [31:0] adc_val,
   input wire dig_in,
   // Logical output
   output reg [15:0] out_val_q,
   output reg [1:0] out_state_q,
   output reg [31:0] out_code_q,
   output reg out_stb_q
);
   // Configuration registers, loaded on cfg_wr; limit pairs loaded on lim_wr
   reg [2:0] mode_q;
   reg [1:0] vrange_q;
   reg irange_q;
   reg fband_q;
   reg [1:0] afilt_q;
   reg [1:0] dbfilt_q;
   reg pol_low_q;
   reg [1:0] sftype_q;
   reg [15:0] sfconst_q;
   reg [31:0] lmax_q [0:4];
   reg [31:0] lmin_q [0:4];
   reg [31:0] range_max;
   reg [31:0] lim_cap;
   integer i;

   // Limits must stay in span and keep max above min
   always @* begin
      case (lim_sel)
         3'd0: lim_cap = `UIA_VLIM;
         3'd1: lim_cap = `UIA_ILIM;
         3'd2: lim_cap = `UIA_RLIM;
         3'd3: lim_cap = `UIA_FLIM;
         default: lim_cap = `UIA_DLIM;
      endcase
   end
   assign lim_rej = lim_wr && (lim_max <= lim_min || lim_max > lim_cap || lim_sel > 3'd4);

   // Setpoint storage; a rejected pair leaves the stored one intact
   always @(posedge sys_clk) begin
      if (reset) begin
         mode_q <= `UIA_MODE_RST;
         vrange_q <= `UIA_VR_RST;
         irange_q <= `UIA_IR_RST;
         fband_q <= `UIA_FB_RST;
         afilt_q <= `UIA_AF_RST;
         dbfilt_q <= `UIA_DB_RST;
         pol_low_q <= `UIA_POL_RST;
         sftype_q <= `UIA_SF_RST;
         sfconst_q <= `UIA_SFK_RST;
         lmax_q[0] <= `UIA_VMAX_RST;
         lmin_q[0] <= `UIA_VMIN_RST;
         lmax_q[1] <= `UIA_IMAX_RST;
         lmin_q[1] <= `UIA_IMIN_RST;
         lmax_q[2] <= `UIA_RMAX_RST;
         lmin_q[2] <= `UIA_RMIN_RST;
         lmax_q[3] <= `UIA_FMAX_RST;
         lmin_q[3] <= `UIA_FMIN_RST;
         lmax_q[4] <= `UIA_DMAX_RST;
         lmin_q[4] <= `UIA_DMIN_RST;
      end else begin
         if (cfg_wr) begin
            mode_q <= (cfg_mode > `UIA_MODE_DUTY) ? mode_q : cfg_mode;
            vrange_q <= cfg_vrange;
            irange_q <= cfg_irange;
            fband_q <= cfg_fband;
            afilt_q <= cfg_afilt;
            dbfilt_q <= cfg_dbfilt;
            pol_low_q <= cfg_pol_low;
            sftype_q <= (cfg_sftype > `UIA_SF_REPEAT) ? sftype_q : cfg_sftype;
            sfconst_q <= (cfg_sfconst > `UIA_SFK_MAX) ? sfconst_q : cfg_sfconst;
         end
         for (i = 0; i < 5; i = i + 1) begin
            if (lim_wr && !lim_rej && lim_sel == i[2:0]) begin
               lmax_q[i] <= lim_max;
               lmin_q[i] <= lim_min;
            end
         end
      end
   end

   // Block average over the analog samples
   reg [6:0] apts;
   reg [6:0] acnt_q;
   reg [38:0] asum_q;
   reg an_stb_q;
   reg [31:0] an_val_q;
   always @* begin
      case (afilt_q)
         `UIA_AF_50: apts = `UIA_AF_PTS_50;
         `UIA_AF_60: apts = `UIA_AF_PTS_60;
         `UIA_AF_BOTH: apts = `UIA_AF_PTS_BOTH;
         default: apts = 7'd1;
      endcase
   end
   wire [38:0] asum_n = asum_q + {7'd0, adc_val};
   wire [38:0] aavg = asum_n / {32'd0, apts};
   // Block averages rather than a sliding window: saves a 90-word memory
   always @(posedge sys_clk) begin
      if (reset) begin
         acnt_q <= 7'd0;
         asum_q <= 39'd0;
         an_stb_q <= 1'b0;
         an_val_q <= 32'd0;
      end else begin
         an_stb_q <= 1'b0;
         if (adc_stb) begin
            if (acnt_q + 1'b1 >= apts) begin
               an_val_q <= aavg[31:0];
               an_stb_q <= 1'b1;
               acnt_q <= 7'd0;
               asum_q <= 39'd0;
            end else begin
               acnt_q <= acnt_q + 1'b1;
               asum_q <= asum_n;
            end
         end
      end
   end

   // Edge debounce for frequency/duty, fixed long debounce for discrete
   reg [31:0] db_cyc;
   always @* begin
      case (dbfilt_q)
         `UIA_DB_111N: db_cyc = `UIA_DB_CYC(`UIA_DB_T1_NS);
         `UIA_DB_1U78: db_cyc = `UIA_DB_CYC(`UIA_DB_T2_NS);
         `UIA_DB_14U22: db_cyc = `UIA_DB_CYC(`UIA_DB_T3_NS);
         default: db_cyc = 32'd1;
      endcase
   end
   wire pin_fast;
   wire pin_slow;
   wire pin_pol = dig_in ^ pol_low_q;
   uia_debounce #(.CNT_W(20)) u_db_fast (
      .sys_clk(sys_clk),
      .reset(reset),
      .bypass(dbfilt_q == `UIA_DB_OFF),
      .hold_cyc(db_cyc[19:0]),
      .din(pin_pol),
      .dout_q(pin_fast)
   );
   uia_debounce #(.CNT_W(24)) u_db_slow (
      .sys_clk(sys_clk),
      .reset(reset),
      .bypass(1'b0),
      .hold_cyc(DISC_DB_CYC[23:0]),
      .din(pin_pol),
      .dout_q(pin_slow)
   );

   // Period and high-time count between rising edges
   reg fast_d1_q;
   reg [31:0] per_q;
   reg [31:0] hi_q;
   reg [31:0] per_cnt_q;
   reg [31:0] hi_cnt_q;
   reg pw_stb_q;
   wire rise = pin_fast && !fast_d1_q;
   // A stalled carrier ends its period at the band floor, read as 0/100 %
   wire stall = per_cnt_q >= (fband_q ? 32'd109229 : 32'd1092296);
   always @(posedge sys_clk) begin
      if (reset) begin
         fast_d1_q <= 1'b0;
         per_q <= 32'd0;
         hi_q <= 32'd0;
         per_cnt_q <= 32'd0;
         hi_cnt_q <= 32'd0;
         pw_stb_q <= 1'b0;
      end else begin
         fast_d1_q <= pin_fast;
         pw_stb_q <= 1'b0;
         if (rise || stall) begin
            per_q <= stall ? 32'd0 : per_cnt_q + 1'b1;
            hi_q <= stall ? {32{pin_fast}} : hi_cnt_q;
            per_cnt_q <= 32'd0;
            hi_cnt_q <= {31'd0, pin_fast};
            pw_stb_q <= 1'b1;
         end else begin
            per_cnt_q <= per_cnt_q + 1'b1;
            hi_cnt_q <= hi_cnt_q + {31'd0, pin_fast};
         end
      end
   end
   // Frequency in mHz and duty in 0.001 %
   wire [63:0] freq_w = (per_q == 32'd0) ? 64'd0 :
      (64'd1000 * TICK_HZ) / {32'd0, per_q};
   wire [63:0] duty_w = (per_q == 32'd0) ? ((hi_q != 32'd0) ? 64'd100000 : 64'd0) :
      ({32'd0, hi_q} * 64'd100000) / {32'd0, per_q};
   // Saturate, so a very fast carrier never wraps back into the band
   wire [31:0] freq = (freq_w[63:32] != 32'd0) ? 32'hffffffff : freq_w[31:0];
   wire band_lo = freq < (fband_q ? `UIA_FHI_MIN : `UIA_FLO_MIN);
   wire band_hi = freq >= (fband_q ? `UIA_FHI_MAX : `UIA_FLO_MAX);

   // Route the measured value for the active mode into the software filter
   reg [31:0] meas;
   reg meas_stb;
   always @* begin
      meas = an_val_q;
      meas_stb = 1'b0;
      case (mode_q)
         `UIA_MODE_VOLT, `UIA_MODE_CURR, `UIA_MODE_RES: meas_stb = an_stb_q;
         `UIA_MODE_FREQ: begin
            meas = freq;
            meas_stb = pw_stb_q;
         end
         `UIA_MODE_DUTY: begin
            meas = duty_w[31:0];
            meas_stb = pw_stb_q;
         end
         default: meas_stb = 1'b0;
      endcase
   end
   wire [31:0] flt_val;
   wire flt_stb;
   uia_swfilter u_swf (
      .sys_clk(sys_clk),
      .reset(reset),
      .ftype(sftype_q),
      .fconst(sfconst_q),
      .smp_stb(meas_stb),
      .smp(meas),
      .val_q(flt_val),
      .val_stb_q(flt_stb)
   );

   // Selected range span and limit pair
   reg [2:0] lidx;
   always @* begin
      lidx = 3'd0;
      range_max = `UIA_VLIM;
      case (mode_q)
         `UIA_MODE_VOLT: begin
            case (vrange_q)
               `UIA_VR_5V: range_max = 32'd5000;
               `UIA_VR_2V5: range_max = 32'd2500;
               `UIA_VR_1V: range_max = 32'd1000;
               default: range_max = `UIA_VLIM;
            endcase
         end
         `UIA_MODE_CURR: begin
            lidx = 3'd1;
            range_max = `UIA_ILIM;
         end
         `UIA_MODE_RES: begin
            lidx = 3'd2;
            range_max = `UIA_RLIM;
         end
         `UIA_MODE_FREQ: begin
            lidx = 3'd3;
            range_max = fband_q ? `UIA_FLIM : 32'd1000000;
         end
         `UIA_MODE_DUTY: begin
            lidx = 3'd4;
            range_max = `UIA_DLIM;
         end
         default: lidx = 3'd0;
      endcase
   end
   wire [31:0] cur_max = lmax_q[lidx];
   wire [31:0] cur_min = lmin_q[lidx];
   wire range_lo = (mode_q == `UIA_MODE_CURR && irange_q == `UIA_IR_4_20) ? 1'b1 : 1'b0;
   wire lim_bad = cur_max > range_max || (range_lo && cur_max < 32'd4000);
   wire [31:0] clip = (flt_val < cur_min) ? cur_min : (flt_val > cur_max) ? cur_max : flt_val;
   wire [47:0] num = {16'd0, clip - cur_min} * 48'd65535;
   wire [47:0] norm_w = num / {16'd0, cur_max - cur_min};

   // Output register: value, state and code for the one logical output
   always @(posedge sys_clk) begin
      if (reset) begin
         out_val_q <= 16'h0;
         out_state_q <= `UIA_ST_VALID;
         out_code_q <= 32'h0;
         out_stb_q <= 1'b0;
      end else begin
         out_stb_q <= 1'b0;
         if (mode_q == `UIA_MODE_OFF) begin
            out_val_q <= 16'h0;
            out_state_q <= `UIA_ST_VALID;
            out_code_q <= 32'h0;
         end else if (mode_q == `UIA_MODE_DISC) begin
            out_val_q <= pin_slow ? `UIA_NORM_ONE : 16'h0;
            out_state_q <= `UIA_ST_VALID;
            out_code_q <= 32'h0;
            out_stb_q <= 1'b1;
         end else if ((pw_stb_q || flt_stb)
                      && (mode_q == `UIA_MODE_FREQ || mode_q == `UIA_MODE_DUTY)
                      && (band_lo || band_hi) && !(mode_q == `UIA_MODE_DUTY && per_q == 32'd0)) begin
            out_val_q <= 16'h0;
            out_state_q <= `UIA_ST_ERROR;
            out_code_q <= band_hi ? `UIA_ERR_HIGH : `UIA_ERR_LOW;
            out_stb_q <= 1'b1;
         end else if (flt_stb) begin
            out_val_q <= lim_bad ? 16'h0 : norm_w[15:0];
            out_state_q <= `UIA_ST_VALID;
            out_code_q <= 32'h0;
            out_stb_q <= 1'b1;
         end
      end
   end
endmodule // uia_acquire

// File: sim/uia_acquire_chk.sv
// Checker for the acquisition block: limit refusal, latency, error output.
// Assumes it is bound to uia_acquire and sees only its ports.
`timescale 1ns/1ns
`include "uia_map.vh"
module uia_acquire_chk (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Configuration
   input wire [2:0] cfg_mode,
   input wire [1:0] cfg_afilt,
   input wire [1:0] cfg_sftype,
   input wire cfg_wr,
   // Limits
   input wire lim_wr,
   input wire [2:0] lim_sel,
   input wire [31:0] lim_max,
   input wire [31:0] lim_min,
   input wire lim_rej,
   // Sample and output
   input wire adc_stb,
   input wire [15:0] out_val_q,
   input wire [1:0] out_state_q,
   input wire out_stb_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   reg [2:0] mode_q;
   reg [1:0] af_q;
   reg [1:0] sf_q;
   // Shadow of the settings, so latency checks know the averaging depth
   always @(posedge sys_clk) begin
      if (reset) begin
         mode_q <= `UIA_MODE_RST;
         af_q <= `UIA_AF_RST;
         sf_q <= `UIA_SF_RST;
      end else if (cfg_wr) begin
         if (cfg_mode <= 3'h6) mode_q <= cfg_mode;
         af_q <= cfg_afilt;
         if (cfg_sftype != 2'h3) sf_q <= cfg_sftype;
      end
   end
   property p_rej_order; lim_wr && (lim_max <= lim_min) |-> lim_rej; endproperty
   a_rej_order: assert property (p_rej_order) else $error("limit pair not refused");
   property p_rej_sel; lim_wr && (lim_sel > 3'h4) |-> lim_rej; endproperty
   a_rej_sel: assert property (p_rej_sel) else $error("bad select not refused");
   property p_rej_cap; lim_wr && lim_sel == 3'h0 && lim_max > `UIA_VLIM |-> lim_rej; endproperty
   a_rej_cap: assert property (p_rej_cap) else $error("volt max over cap taken");
   property p_take_ok;
      lim_wr && lim_sel == 3'h0 && lim_max > lim_min && lim_max <= `UIA_VLIM |-> !lim_rej;
   endproperty
   a_take_ok: assert property (p_take_ok) else $error("good volt pair refused");
   property p_err_zero; out_state_q == `UIA_ST_ERROR |-> out_val_q == 16'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("error state with value");
   property p_quiet;
      $fell(reset) |-> !out_stb_q && out_val_q == 16'h0 && out_state_q == 2'h0;
   endproperty
   a_quiet: assert property (p_quiet) else $error("outputs not cleared by reset");
   property p_ana_lat;
      mode_q == `UIA_MODE_VOLT && af_q == `UIA_AF_OFF && sf_q == `UIA_SF_NONE && adc_stb
         |-> !out_stb_q [*3] ##1 out_stb_q;
   endproperty
   a_ana_lat: assert property (p_ana_lat) else $error("analog strobe latency wrong");
   property p_disc_lvl;
      mode_q == `UIA_MODE_DISC && $stable(mode_q) && out_stb_q
         |-> out_val_q == 16'h0 || out_val_q == `UIA_NORM_ONE;
   endproperty
   a_disc_lvl: assert property (p_disc_lvl) else $error("discrete value not 0 or 1");
   c_rej: cover property (lim_wr && lim_rej);
   c_err: cover property (out_state_q == `UIA_ST_ERROR);
   c_ana: cover property (af_q == `UIA_AF_OFF && adc_stb ##3 out_stb_q);
endmodule // uia_acquire_chk

bind uia_acquire uia_acquire_chk u_chk (.sys_clk(sys_clk), .reset(reset),
   .cfg_mode(cfg_mode), .cfg_afilt(cfg_afilt), .cfg_sftype(cfg_sftype), .cfg_wr(cfg_wr),
   .lim_wr(lim_wr), .lim_sel(lim_sel), .lim_max(lim_max), .lim_min(lim_min),
   .lim_rej(lim_rej), .adc_stb(adc_stb), .out_val_q(out_val_q),
   .out_state_q(out_state_q), .out_stb_q(out_stb_q));

// File: sim/uia_sink.sv
// Downstream consumer model: counts each output strobe, without latching the value.
// Assumes one strobe per new value on sys_clk.
`timescale 1ns/1ns
module uia_sink (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Logical input
   input wire out_stb_q,
   // Consumed count
   output reg [31:0] stb_cnt_q
);
   // Count only, the bench compares the values itself
   always @(posedge sys_clk) begin
      if (reset) stb_cnt_q <= 32'h0;
      else if (out_stb_q) stb_cnt_q <= stb_cnt_q + 32'h1;
   end
endmodule // uia_sink

// File: sim/uia_acquire_tb.sv
// Self-checking bench for uia_acquire with a short discrete debounce.
// Assumes the sink model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`include "uia_map.vh"
module uia_acquire_tb;
   reg sys_clk, reset, cfg_irange, cfg_fband, cfg_pol_low, cfg_wr, lim_wr, adc_stb, dig_in;
   reg [2:0] cfg_mode, lim_sel;
   reg [1:0] cfg_vrange, cfg_afilt, cfg_dbfilt, cfg_sftype;
   reg [15:0] cfg_sfconst;
   reg [31:0] lim_max, lim_min, adc_val, rnd, v, cyc;
   wire lim_rej, out_stb_q;
   wire [15:0] out_val_q;
   wire [1:0] out_state_q;
   wire [31:0] out_code_q, stb_cnt_q;
   integer bad_count, comparisons, i, r;
   reg got;
   uia_acquire #(.DISC_DB_CYC(20)) uut (.sys_clk(sys_clk), .reset(reset),
      .cfg_mode(cfg_mode), .cfg_vrange(cfg_vrange), .cfg_irange(cfg_irange),
      .cfg_fband(cfg_fband), .cfg_afilt(cfg_afilt), .cfg_dbfilt(cfg_dbfilt),
      .cfg_pol_low(cfg_pol_low), .cfg_sftype(cfg_sftype), .cfg_sfconst(cfg_sfconst),
      .cfg_wr(cfg_wr), .lim_wr(lim_wr), .lim_sel(lim_sel), .lim_max(lim_max),
      .lim_min(lim_min), .lim_rej(lim_rej), .adc_stb(adc_stb), .adc_val(adc_val),
      .dig_in(dig_in), .out_val_q(out_val_q), .out_state_q(out_state_q),
      .out_code_q(out_code_q), .out_stb_q(out_stb_q));
   uia_sink u_sink (.sys_clk(sys_clk), .reset(reset), .out_stb_q(out_stb_q),
      .stb_cnt_q(stb_cnt_q));
   // Clock, 100 ns period
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Hang guard, far above the expected run length
   always @(posedge sys_clk) begin
      cyc <= cyc + 32'h1;
      if (cyc == 32'd20000) begin
         bad_count = bad_count + 1;
         tally_and_finish;
      end
   end
   // Expected normalized value, input clipped into the limit pair
   function [15:0] nv(input [31:0] x, input [31:0] mn, input [31:0] mx);
      reg [63:0] c;
      begin
         c = (x < mn) ? mn : (x > mx) ? mx : x;
         nv = ((c - mn) * 64'd65535) / (mx - mn);
      end
   endfunction
   task chk_val(input [15:0] got_v, input [15:0] exp_v);
      begin
         comparisons = comparisons + 1;
         if (got_v !== exp_v) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t value %h expected %h", $time, got_v, exp_v);
         end
      end
   endtask
   task chk_word(input [31:0] got_v, input [31:0] exp_v);
      begin
         comparisons = comparisons + 1;
         if (got_v !== exp_v) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t word %h expected %h", $time, got_v, exp_v);
         end
      end
   endtask
   // All settings load together on one strobe
   task cfg(input [2:0] m, input [1:0] vr, input ir, input [1:0] af, input [1:0] db,
      input pl);
      begin
         @(posedge sys_clk);
         cfg_mode <= m; cfg_vrange <= vr; cfg_irange <= ir; cfg_afilt <= af;
         cfg_dbfilt <= db; cfg_pol_low <= pl; cfg_sftype <= `UIA_SF_NONE;
         cfg_sfconst <= $urandom % 60001;
         cfg_wr <= 1'b1;
         @(posedge sys_clk);
         cfg_wr <= 1'b0;
      end
   endtask
   // Refusal is combinational, so it is looked at mid-cycle
   task lim(input [2:0] s, input [31:0] mx, input [31:0] mn, input exp_r);
      begin
         @(posedge sys_clk);
         lim_wr <= 1'b1; lim_sel <= s; lim_max <= mx; lim_min <= mn;
         #50 chk_word({31'h0, lim_rej}, {31'h0, exp_r});
         @(posedge sys_clk);
         lim_wr <= 1'b0;
      end
   endtask
   task smp(input [31:0] x, input wt);
      begin
         @(posedge sys_clk);
         adc_stb <= 1'b1; adc_val <= x;
         @(posedge sys_clk);
         adc_stb <= 1'b0; adc_val <= $urandom;
         got = 1'b0;
         for (i = 0; i < 12; i = i + 1)
            if (wt && !got) begin
               @(posedge sys_clk);
               #1 got = (out_stb_q === 1'b1);
            end
         if (wt && !got) chk_word(32'h0, 32'h1);
      end
   endtask
   task tally_and_finish;
      begin
         $display("comparisons %0d bad_count %0d", comparisons, bad_count);
         if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      bad_count = 0; comparisons = 0; cyc = 32'h0;
      reset = 1'b1; cfg_wr = 1'b0; lim_wr = 1'b0; adc_stb = 1'b0; dig_in = 1'b0;
      cfg_mode = 3'h0; cfg_vrange = 2'h0; cfg_irange = 1'b0; cfg_fband = 1'b0;
      cfg_afilt = 2'h0; cfg_dbfilt = 2'h0; cfg_pol_low = 1'b0; cfg_sftype = 2'h0;
      cfg_sfconst = 16'h0; lim_sel = 3'h0; lim_max = 32'h0; lim_min = 32'h0; adc_val = 32'h0;
      rnd = $urandom(32'ha1c9ed5c);
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      // Defaults: volt, both-notch average of 90, limits 0..5 V
      for (r = 0; r < 89; r = r + 1) smp(32'd2500, 1'b0);
      chk_word(stb_cnt_q, 32'h0);
      smp(32'd2500, 1'b1);
      chk_val(out_val_q, nv(2500, `UIA_VMIN_RST, `UIA_VMAX_RST));
      // Limit writes: refusals keep the stored pair
      cfg(`UIA_MODE_VOLT, `UIA_VR_10V, 1'b0, `UIA_AF_OFF, `UIA_DB_1U78, 1'b0);
      lim(3'h0, 32'd4000, 32'd1000, 1'b0);
      lim(3'h0, 32'd900, 32'd900, 1'b1);
      lim(3'h0, 32'd20000, 32'd0, 1'b1);
      lim(3'h5, 32'd9, 32'd1, 1'b1);
      smp(32'd2500, 1'b1);
      chk_val(out_val_q, nv(2500, 1000, 4000));
      for (r = 0; r < 20; r = r + 1) begin
         v = $urandom % 5001;
         smp(v, 1'b1);
         chk_val(out_val_q, nv(v, 1000, 4000));
      end
      // Every voltage span against limits 0..2 V
      lim(3'h0, 32'd2000, 32'd0, 1'b0);
      for (r = 0; r < 4; r = r + 1) begin
         cfg(`UIA_MODE_VOLT, r[1:0], 1'b0, `UIA_AF_OFF, `UIA_DB_1U78, 1'b0);
         smp(32'd1000, 1'b1);
         chk_val(out_val_q, (2000 > (r == 0 ? 10000 : r == 1 ? 5000 : r == 2 ? 2500 : 1000))
            ? 16'h0 : nv(1000, 0, 2000));
      end
      // Current 4-20 span and resistance defaults
      cfg(`UIA_MODE_CURR, 2'h0, `UIA_IR_4_20, `UIA_AF_OFF, `UIA_DB_1U78, 1'b0);
      smp(32'd10000, 1'b1);
      chk_val(out_val_q, nv(10000, `UIA_IMIN_RST, `UIA_IMAX_RST));
      lim(3'h1, 32'd3000, 32'd0, 1'b0);
      smp(32'd2000, 1'b1);
      chk_val(out_val_q, 16'h0);
      cfg(`UIA_MODE_RES, 2'h0, 1'b0, `UIA_AF_OFF, `UIA_DB_1U78, 1'b0);
      smp(32'd125015, 1'b1);
      chk_val(out_val_q, nv(125015, `UIA_RMIN_RST, `UIA_RMAX_RST));
      // Discrete level, 20-cycle debounce, both polarities
      cfg(`UIA_MODE_DISC, 2'h0, 1'b0, `UIA_AF_OFF, `UIA_DB_OFF, 1'b0);
      dig_in <= 1'b1;
      repeat (30) @(posedge sys_clk);
      #1 chk_val(out_val_q, `UIA_NORM_ONE);
      dig_in <= 1'b0;
      repeat (10) @(posedge sys_clk);
      #1 chk_val(out_val_q, `UIA_NORM_ONE);
      repeat (25) @(posedge sys_clk);
      #1 chk_val(out_val_q, 16'h0);
      cfg(`UIA_MODE_DISC, 2'h0, 1'b0, `UIA_AF_OFF, `UIA_DB_OFF, 1'b1);
      repeat (30) @(posedge sys_clk);
      #1 chk_val(out_val_q, `UIA_NORM_ONE);
      // Carrier far above the low band in frequency and duty modes
      for (r = 5; r < 7; r = r + 1) begin
         cfg(r[2:0], 2'h0, 1'b0, `UIA_AF_OFF, `UIA_DB_OFF, 1'b0);
         for (i = 0; i < 40; i = i + 1) @(posedge sys_clk) dig_in <= ~dig_in;
         #1 chk_word({30'h0, out_state_q}, {30'h0, `UIA_ST_ERROR});
         chk_word(out_code_q, `UIA_ERR_HIGH);
         chk_val(out_val_q, 16'h0);
      end
      tally_and_finish;
   end
endmodule // uia_acquire_tb
